/* core/tws_regs.vh */
// Purpose: Constants for the two-wire EEPROM slave protocol engine
// Assumes: Plain Verilog-2005, included by bare name
// Notes: No software-visible registers; these are protocol constants
// Operation
// - Data on SDA stays steady while SCL high; change then is Start/Stop.
// - Start is SDA falling with SCL high; precedes every command.
// - Watch both lines but ignore all activity until a Start.
// - Receiver of a good byte drives SDA low on the ninth clock.
// - Any new Start resets protocol state after an interrupted transfer.
// - Go idle after reset, after Stop ending non-write, after programming.
// - Accept address byte only when upper four bits are 1010.
// - Two address bits pick one of four 256-byte blocks.
// - One address bit must equal the hardwired select pin level.
// - Address byte bit 0 selects read when 1, write when 0.
// - Matching address byte is acknowledged on the ninth clock.
// - Byte write: address, byte address, data; program on Stop.
// - Ignore all master requests while internal programming runs.
// - Page write takes up to 16 bytes, each acknowledged at once.
// - Page write bumps only low four address bits, wrapping in page.
// - Over 16 bytes overwrite buffered ones; all programmed after Stop.
// - Poll: no acknowledge while programming, acknowledge once done.
// - Counter holds last address plus one; read returns it, wraps to 0.
// - Sequential read sends next byte after each master acknowledge.
// - Sequential read wraps counter from last location to 0.
// - Write-inhibit pin high blocks all array writes.
// - Array holds 1,024 bytes of 8 bits in 16-byte pages.
`ifndef TWS_REGS_VH
`define TWS_REGS_VH
`define TWS_DEV_PREFIX 4'b1010
`define TWS_ADDR_W 10
`define TWS_PAGE_W 4
`define TWS_MEM_DEPTH 1024
`define TWS_TWR_US 3
`define TWS_CLK_MHZ 250
`define TWS_TWR_CYC (`TWS_TWR_US * `TWS_CLK_MHZ)
`endif

/* core/tws_sync.v */
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs come from outside the clock domain
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module tws_sync #(
    parameter W = 3
) (
    // Clock and reset
    input wire clock_i,
    input wire resetn_i,
    input wire ce_i,
    // Data
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);
    reg [W-1:0] meta_r;
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_r <= {W{1'b1}};
            q_o <= {W{1'b1}};
        end else if (ce_i) begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule // tws_sync
`default_nettype wire

/* core/tws_buf2.v */
// Purpose: Two-entry valid/ready buffer
// Assumes: Same clock on both sides
// Notes: Full and empty are exact; a stalled drain fills it
`timescale 1ns/100ps
`default_nettype none
module tws_buf2 #(
    parameter W = 8
) (
    // Clock and reset
    input wire clock_i,
    input wire resetn_i,
    input wire ce_i,
    // Fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    // Drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem_r [0:1];
    reg wp_r;
    reg rp_r;
    reg [1:0] cnt_r;
    wire push;
    wire pop;
    assign in_ready_o = (cnt_r != 2'd2);
    assign out_valid_o = (cnt_r != 2'd0);
    assign out_data_o = mem_r[rp_r];
    assign push = in_valid_i && in_ready_o && ce_i;
    assign pop = out_valid_o && out_ready_i && ce_i;
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'd0;
            mem_r[0] <= {W{1'b0}};
            mem_r[1] <= {W{1'b0}};
        end else begin
            if (push) begin
                mem_r[wp_r] <= in_data_i;
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 2'd1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 2'd1;
            end
        end
    end
endmodule // tws_buf2
`default_nettype wire

/* core/tws_eeprom.v */
// Purpose: Slave-side two-wire protocol engine of a 1,024-byte EEPROM
// Assumes: SCL and SDA are sampled by clock_i, far faster than SCL
// Notes: Received write bytes pass a two-entry buffer into the page latch
`timescale 1ns/100ps
`default_nettype none
`include "tws_regs.vh"
module tws_eeprom #(
    parameter TWR_CYC = `TWS_TWR_CYC,
    parameter AW = `TWS_ADDR_W,
    parameter PW = `TWS_PAGE_W
) (
    // Clock, reset, enable
    input wire clock_i,
    input wire resetn_i,
    input wire ce_i,
    // Two-wire bus, SDA open drain
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oen_o,
    // Straps
    input wire hardwired_select_pin_i,
    input wire write_inhibit_i,
    // Status
    output reg busy_o,
    output reg standby_o
);
    localparam DEPTH = 1 << AW;
    localparam PAGE = 1 << PW;
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_DEV = 3'd1;
    localparam [2:0] S_WADDR = 3'd2;
    localparam [2:0] S_WDATA = 3'd3;
    localparam [2:0] S_RDATA = 3'd4;
    localparam [2:0] S_RACK = 3'd5;

    // Pin synchronisers
    // Both straps are pins as well, so they share the synchroniser
    wire [3:0] pins_s;
    tws_sync #(.W(4)) u_sync (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .d_i({hardwired_select_pin_i, scl_i, sda_i, write_inhibit_i}),
        .q_o(pins_s)
    );
    wire sel_s = pins_s[3];
    wire scl_s = pins_s[2];
    wire sda_s = pins_s[1];
    wire wp_s = pins_s[0];
    reg scl_d_r;
    reg sda_d_r;
    wire scl_rise = scl_s && !scl_d_r;
    wire scl_fall = !scl_s && scl_d_r;
    // Only an SDA move while SCL stays high is a condition
    wire start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
    wire stop_ev = scl_s && scl_d_r && !sda_d_r && sda_s;

    // Storage
    reg [7:0] mem_r [0:DEPTH-1];
    reg [7:0] page_r [0:PAGE-1];
    reg [PAGE-1:0] pvld_r;
    reg [AW-1:0] ptr_r;
    reg [AW-PW-1:0] pbase_r;

    reg [2:0] st_r;
    reg [3:0] bit_r;
    reg [7:0] sh_r;
    reg ackph_r;
    reg wrote_r;
    reg [31:0] twr_r;
    reg [AW-1:0] wptr_r;

    // Received write bytes travel through the buffer
    reg bin_v;
    reg [7:0] bin_d;
    wire bin_rdy;
    wire bout_v;
    wire [7:0] bout_d;
    wire bout_rdy = 1'b1;
    tws_buf2 #(.W(8)) u_buf (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .in_valid_i(bin_v),
        .in_ready_o(bin_rdy),
        .in_data_i(bin_d),
        .out_valid_o(bout_v),
        .out_ready_i(bout_rdy),
        .out_data_o(bout_d)
    );

    integer i;

    // Array and page latch
    always @(posedge clock_i) begin
        if (ce_i) begin
            if (bout_v) begin
                page_r[wptr_r[PW-1:0]] <= bout_d;
            end
            if (busy_o && twr_r == 32'd1 && !wp_s) begin
                for (i = 0; i < PAGE; i = i + 1) begin
                    if (pvld_r[i]) begin
                        mem_r[{pbase_r, i[PW-1:0]}] <= page_r[i];
                    end
                end
            end
        end
    end

    wire addr_hit = (sh_r[7:4] == `TWS_DEV_PREFIX)
                    && (sh_r[3] == sel_s);

    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            st_r <= S_IDLE;
            bit_r <= 4'd0;
            sh_r <= 8'h00;
            ackph_r <= 1'b0;
            wrote_r <= 1'b0;
            twr_r <= 32'd0;
            ptr_r <= {AW{1'b0}};
            wptr_r <= {AW{1'b0}};
            pbase_r <= {(AW-PW){1'b0}};
            pvld_r <= {PAGE{1'b0}};
            bin_v <= 1'b0;
            bin_d <= 8'h00;
            sda_o <= 1'b1;
            sda_oen_o <= 1'b1;
            busy_o <= 1'b0;
            standby_o <= 1'b1;
        end else if (ce_i) begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            bin_v <= 1'b0;
            if (busy_o) begin
                // Bus ignored while programming
                sda_oen_o <= 1'b1;
                st_r <= S_IDLE;
                if (twr_r == 32'd1) begin
                    busy_o <= 1'b0;
                    standby_o <= 1'b1;
                    pvld_r <= {PAGE{1'b0}};
                end
                twr_r <= twr_r - 32'd1;
            end else if (start_ev) begin
                // Fresh start from any state
                st_r <= S_DEV;
                bit_r <= 4'd0;
                ackph_r <= 1'b0;
                sda_oen_o <= 1'b1;
                standby_o <= 1'b0;
            end else if (stop_ev) begin
                st_r <= S_IDLE;
                sda_oen_o <= 1'b1;
                if (wrote_r) begin
                    busy_o <= 1'b1;
                    twr_r <= TWR_CYC;
                    wrote_r <= 1'b0;
                end else begin
                    // Drop bytes that will never be programmed
                    pvld_r <= {PAGE{1'b0}};
                    standby_o <= 1'b1;
                end
            end else if (st_r != S_IDLE) begin
                if (scl_rise && !ackph_r && st_r != S_RDATA
                    && st_r != S_RACK) begin
                    sh_r <= {sh_r[6:0], sda_s};
                    bit_r <= bit_r + 4'd1;
                end
                if (scl_rise && st_r == S_RACK) begin
                    // Master acknowledge asks for more
                    if (sda_s) begin
                        st_r <= S_IDLE;
                    end else begin
                        // Next falling edge loads the following byte
                        st_r <= S_RDATA;
                        ackph_r <= 1'b1;
                    end
                    bit_r <= 4'd0;
                end
                if (scl_fall) begin
                    if (ackph_r) begin
                        ackph_r <= 1'b0;
                        sda_oen_o <= 1'b1;
                        bit_r <= 4'd0;
                        if (st_r == S_RDATA) begin
                            sda_o <= 1'b0;
                            sda_oen_o <= mem_r[ptr_r][7];
                            sh_r <= mem_r[ptr_r];
                        end
                    end else if (st_r == S_RDATA) begin
                        // Bit 7 went out at the ack fall; seven remain
                        if (bit_r == 4'd7) begin
                            sda_oen_o <= 1'b1;
                            st_r <= S_RACK;
                            ptr_r <= ptr_r + 1'b1;
                        end else begin
                            sda_oen_o <= sh_r[3'd6 - bit_r[2:0]];
                            bit_r <= bit_r + 4'd1;
                        end
                    end else if (bit_r == 4'd8) begin
                        ackph_r <= 1'b1;
                        sda_o <= 1'b0;
                        sda_oen_o <= 1'b0;
                        case (st_r)
                            S_DEV: begin
                                if (addr_hit) begin
                                    ptr_r[AW-1:AW-2] <= sh_r[2:1];
                                    if (sh_r[0]) begin
                                        st_r <= S_RDATA;
                                    end else begin
                                        st_r <= S_WADDR;
                                    end
                                end else begin
                                    sda_oen_o <= 1'b1;
                                    ackph_r <= 1'b0;
                                    st_r <= S_IDLE;
                                end
                            end
                            S_WADDR: begin
                                ptr_r[7:0] <= sh_r;
                                pbase_r <= {ptr_r[AW-1:AW-2], sh_r[7:PW]};
                                st_r <= S_WDATA;
                            end
                            S_WDATA: begin
                                if (bin_rdy) begin
                                    bin_v <= 1'b1;
                                    bin_d <= sh_r;
                                end
                                wptr_r <= ptr_r;
                                pvld_r[ptr_r[PW-1:0]] <= 1'b1;
                                wrote_r <= !wp_s;
                                ptr_r[PW-1:0] <= ptr_r[PW-1:0] + 1'b1;
                            end
                            default: begin
                                st_r <= S_IDLE;
                            end
                        endcase
                    end
                end
            end
        end
    end
    // Polling answer: a busy device never acks
endmodule // tws_eeprom
`default_nettype wire

/* bench/tws_eeprom_sva.sv */
// Purpose: Pin-level assertions on the EEPROM slave engine
// Assumes: ce_i held high; SDA wired-and with a pull-up
// Notes: Programming length is measured by a small counter
`timescale 1ns/100ps
`default_nettype none
module tws_eeprom_sva #(
    parameter TWR_CYC = 750
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Bus and straps
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oen_o,
    input wire logic hardwired_select_pin_i,
    input wire logic write_inhibit_i,
    // Status
    input wire logic busy_o,
    input wire logic standby_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    reg [15:0] busy_cnt_r;
    wire [15:0] busy_cnt_nxt = busy_o ? busy_cnt_r + 16'h0001 : 16'h0000;
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_cnt_r <= 16'h0000;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end
    sequence start_s;
        scl_i && $fell(sda_i);
    endsequence
    sequence stop_s;
        scl_i && $rose(sda_i);
    endsequence
    AST_DRIVE_LOW: assert property (!sda_oen_o |-> !sda_o)
        else $error("SDA driven high");
    AST_BUSY_QUIET: assert property (busy_o |-> sda_oen_o)
        else $error("SDA driven while programming");
    AST_BUSY_LEN: assert property ($fell(busy_o) |->
        busy_cnt_r >= TWR_CYC - 2 && busy_cnt_r <= TWR_CYC + 2)
        else $error("Programming length wrong");
    AST_IDLE_AFTER: assert property ($fell(busy_o) |-> ##[0:2] standby_o)
        else $error("No standby after programming");
    AST_IDLE_EXCL: assert property (busy_o |-> !standby_o)
        else $error("Standby while programming");
    AST_IDLE_QUIET: assert property (standby_o |-> sda_oen_o)
        else $error("SDA driven in standby");
    AST_SCL_LOW_CHG: assert property ($changed(sda_oen_o) |-> !scl_i)
        else $error("SDA changed with SCL high");
    AST_START_REL: assert property (start_s |=> sda_oen_o[*8])
        else $error("SDA driven after Start");
    AST_STOP_REL: assert property (stop_s |=> sda_oen_o[*8])
        else $error("SDA driven after Stop");
endmodule // tws_eeprom_sva
bind tws_eeprom tws_eeprom_sva #(.TWR_CYC(TWR_CYC)) i_tws_eeprom_sva (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oen_o(sda_oen_o),
    .hardwired_select_pin_i(hardwired_select_pin_i),
    .write_inhibit_i(write_inhibit_i), .busy_o(busy_o),
    .standby_o(standby_o));
`default_nettype wire

/* bench/tws_master.sv */
// Purpose: Two-wire bus master model
// Assumes: SDA output 1 means released; the pull-up is in the bench
// Notes: Each step is 10 clocks, so one bit lasts 160 ns
`timescale 1ns/100ps
`default_nettype none
module tws_master (
    // Clock
    input wire logic clock_i,
    // Bus
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic step(input logic c, input logic d);
        scl_o <= c;
        sda_o <= d;
        repeat (10) @(posedge clock_i);
    endtask
    task automatic start();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    // Data moves only while SCL is low
    task automatic xbit(input logic b, output logic r);
        step(1'b0, b);
        step(1'b1, b);
        r = sda_i;
        step(1'b1, b);
        step(1'b0, b);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(b[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(1'b1, b[i]);
        xbit(!mack, r);
    endtask
endmodule // tws_master
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the EEPROM slave engine
// Assumes: Short programming time so polling stays cheap
// Notes: Array content is checked only by reading it back
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic pin = 1'b0;
    logic inhibit = 1'b0;
    wire logic scl;
    wire logic m_sda;
    wire logic d_sda;
    wire logic d_oen;
    wire logic busy;
    wire logic standby;
    wire logic sda_w = m_sda & (d_oen | d_sda);
    int failures = 0;
    int checked = 0;
    logic [7:0] exp_q [0:17];
    logic [7:0] rd_b;
    logic ak;
    always #2 clock_i = ~clock_i;
    tws_eeprom #(.TWR_CYC(600)) i_tws_eeprom (.clock_i(clock_i),
        .resetn_i(resetn_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda_w),
        .sda_o(d_sda), .sda_oen_o(d_oen), .hardwired_select_pin_i(pin),
        .write_inhibit_i(inhibit), .busy_o(busy), .standby_o(standby));
    tws_master i_tws_master (.clock_i(clock_i), .sda_i(sda_w),
        .scl_o(scl), .sda_o(m_sda));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: data %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: flag %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] dev(input logic [9:0] a, input logic rw);
        return {4'b1010, pin, a[9:8], rw};
    endfunction
    task automatic send(input logic [7:0] b, input logic e);
        i_tws_master.wbyte(b, ak);
        chk1(ak, e);
    endtask
    task automatic wr(input logic [9:0] a, input int n, input logic [7:0] d);
        i_tws_master.start();
        send(dev(a, 1'b0), 1'b1);
        send(a[7:0], 1'b1);
        for (int k = 0; k < n; k++) send(d + k[7:0], 1'b1);
        i_tws_master.stop();
    endtask
    task automatic poll();
        ak = 1'b0;
        for (int k = 0; k < 6 && !ak; k++) begin
            i_tws_master.start();
            i_tws_master.wbyte(dev(10'h000, 1'b0), ak);
            i_tws_master.stop();
        end
        chk1(ak, 1'b1);
    endtask
    task automatic rd(input logic [9:0] a, input int n);
        i_tws_master.start();
        send(dev(a, 1'b0), 1'b1);
        send(a[7:0], 1'b1);
        i_tws_master.start();
        send(dev(a, 1'b1), 1'b1);
        for (int k = 0; k < n; k++) begin
            i_tws_master.rbyte(k < n - 1, rd_b);
            chk8(rd_b, exp_q[k]);
        end
        i_tws_master.stop();
    endtask
    task automatic sc_addr();
        i_tws_master.start();
        send(8'hB0, 1'b0);
        i_tws_master.start();
        send({4'b1010, ~pin, 3'b000}, 1'b0);
        pin <= 1'b1;
        i_tws_master.start();
        send(dev(10'h000, 1'b0), 1'b1);
        i_tws_master.stop();
    endtask
    task automatic sc_byte();
        wr(10'h2F3, 1, 8'hA5);
        chk1(busy, 1'b1);
        i_tws_master.start();
        send(dev(10'h000, 1'b0), 1'b0);
        i_tws_master.stop();
        poll();
        chk1(busy, 1'b0);
        chk1(standby, 1'b1);
        exp_q[0] = 8'hA5;
        rd(10'h2F3, 1);
    endtask
    // Eighteen bytes from offset 14: the last two land on 14 and 15 again
    task automatic sc_page();
        wr(10'h10E, 18, 8'h40);
        poll();
        for (int o = 0; o < 16; o++) exp_q[o] = 8'h42 + o[7:0];
        rd(10'h100, 15);
        i_tws_master.start();
        send(dev(10'h100, 1'b1), 1'b1);
        i_tws_master.rbyte(1'b0, rd_b);
        i_tws_master.stop();
        chk8(rd_b, 8'h51);
    endtask
    task automatic sc_wrap();
        wr(10'h3FF, 1, 8'h5A);
        poll();
        wr(10'h000, 1, 8'h3C);
        poll();
        exp_q[0] = 8'h5A;
        exp_q[1] = 8'h3C;
        rd(10'h3FF, 2);
    endtask
    task automatic sc_inhibit();
        inhibit <= 1'b1;
        wr(10'h000, 1, 8'hFF);
        chk1(busy, 1'b0);
        poll();
        inhibit <= 1'b0;
        exp_q[0] = 8'h3C;
        rd(10'h000, 1);
    endtask
    task automatic give_verdict();
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock_i);
        failures++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        chk1(standby, 1'b1);
        sc_addr();
        sc_byte();
        sc_page();
        sc_wrap();
        sc_inhibit();
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
